// >>> rtl/uart_channel_fifo_dma_defs.vh
`ifndef UART_CHANNEL_FIFO_DMA_DEFS_VH
`define UART_CHANNEL_FIFO_DMA_DEFS_VH

// ---------------------------------------------------------------
// Register offsets, relative to the channel base
// ---------------------------------------------------------------
`define OFS_STATUS 5'h04
`define OFS_TX_PTR_COUNT 5'h08
`define OFS_RX_PTR 5'h0C

// ---------------------------------------------------------------
// Channel status bit positions
// ---------------------------------------------------------------
`define ST_IRQ 31
`define ST_LOCAL_IRQ 30
`define ST_TX_IDLE 29
`define ST_TX_DMA_IDLE 23
`define ST_RX_DMA_IDLE 22
`define ST_RX_PARITY 19
`define ST_RX_OVERFLOW 18
`define ST_RX_FRAME 16
`define ST_RX_DMA_DONE 15
`define ST_TX_DMA_DONE 14
`define ST_RX_DMA_ERR 13
`define ST_TX_DMA_ERR 12
`define ST_RX_HIGH 11
`define ST_TX_LOW 10
`define ST_TX_DONE 8
`define ST_RX_FULL 6
`define ST_RX_AFULL 5
`define ST_RX_EMPTY 4
`define ST_TX_FULL 2
`define ST_TX_AEMPTY 1
`define ST_TX_EMPTY 0

// ---------------------------------------------------------------
// Descriptor pointer fields and timing
// ---------------------------------------------------------------
`define PTR_DIR_BIT 1
`define PTR_EOC_BIT 0
`define DIR_TX 1'b0
`define DIR_RX 1'b1
`define TX_SM_DIVIDE 4'hF
`define RX_PIPE_DEPTH 4
`define RESET_WORD 32'h00000000

`endif

// >>> rtl/uart_channel_fifo_dma.v
// How it works
// - Separate 2Kx32 transmit and receive FIFOs; transmit count is readable.
// - Flags active high; full/empty from DMA FIFOs, but receive empty and almost full also count the pipeline.
// - With both DMA FIFOs and the pipeline empty and nonzero watermarks the low status bits read 0x13.
// - Receive empty reads one only if FIFO and 4-deep pipeline are empty.
// - Receive almost full when FIFO plus pipeline reaches high watermark.
// - Storing into a full receive FIFO sets sticky overflow; write one clears.
// - Transmit FIFO empty when the transmitter needs a word is an underflow.
// - Transmit almost empty while word count is below the low watermark.
// - Aborts or wrong direction in a next pointer set sticky DMA error.
// - A finished descriptor list latches the per-direction DMA done flag.
// - Each DMA direction shows idle as 1, busy as 0; start only when idle.
// - Local irq merges enabled non-DMA sources; request adds DMA and master.
// - Transmitter idle flag follows the transmit machine running at clock/16.
// - Transmit FIFO turning almost empty sets a sticky flag; write one clears.
// - Receive FIFO turning almost full sets a sticky flag; write one clears.
// - Received framing mismatch sets a sticky framing error; write one clears.
// - Received parity mismatch sets a sticky parity error; write one clears.
// - Transmit FIFO empty when the next word is due latches transmit done.
// - Pointer write starts DMA; fetch address, length, next until end of chain.
// - Writing zero to the transmit pointer aborts a running transmit DMA.
`include "uart_channel_fifo_dma_defs.vh"
`default_nettype none

module uart_channel_fifo_dma #(
	parameter AW = 11,
	parameter DW = 32
) (
	input wire i_clk,
	input wire i_rst,
	input wire [4:0] i_reg_addr,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [31:0] i_reg_wdata,
	output reg [31:0] o_reg_rdata,
	output reg o_reg_rdata_valid,
	input wire i_tx_fifo_reset,
	input wire i_rx_fifo_reset,
	input wire i_chan_irq_en,
	input wire i_force_irq,
	input wire i_tx_dma_irq_en,
	input wire i_rx_dma_irq_en,
	input wire i_tx_low_irq_en,
	input wire i_rx_high_irq_en,
	input wire i_rx_ovf_irq_en,
	input wire i_tx_done_irq_en,
	input wire i_tx_start,
	input wire [AW:0] i_tx_low_watermark,
	input wire [AW:0] i_rx_high_watermark,
	input wire i_rx_word_valid,
	input wire [DW-1:0] i_rx_word,
	input wire i_rx_parity_err,
	input wire i_rx_frame_err,
	output reg o_tx_word_valid,
	output reg [DW-1:0] o_tx_word,
	input wire i_tx_word_ready,
	output reg o_tx_underflow,
	output reg o_mem_req,
	output reg o_mem_we,
	output reg [31:0] o_mem_addr,
	output reg [31:0] o_mem_wdata,
	input wire i_mem_ack,
	input wire [31:0] i_mem_rdata,
	input wire i_mem_target_abort,
	input wire i_mem_master_abort,
	output reg o_irq
);

	localparam DEPTH = 1 << AW;
	localparam TS_IDLE = 3'b001;
	localparam TS_SEND = 3'b010;
	localparam TS_STOP = 3'b100;
	localparam DS_IDLE = 3'b001;
	localparam DS_FETCH = 3'b010;
	localparam DS_XFER = 3'b100;

	// -----------------------------------------------------------
	// Storage and state
	// -----------------------------------------------------------
	reg [DW-1:0] tx_mem [0:DEPTH-1];
	reg [DW-1:0] rx_mem [0:DEPTH-1];
	reg [AW-1:0] tx_wptr_reg, tx_rptr_reg, rx_wptr_reg, rx_rptr_reg;
	reg [AW:0] tx_count_reg, rx_count_reg;
	reg [DW-1:0] pipe_d [0:`RX_PIPE_DEPTH-1];
	reg [`RX_PIPE_DEPTH-1:0] pipe_v;
	reg [DW-1:0] buf1_d;
	reg buf1_v;
	reg [3:0] div_reg;
	reg tick_reg;
	reg [2:0] ts_reg;
	reg [2:0] ds_reg;
	reg dir_reg, eoc_reg;
	reg [1:0] idx_reg;
	reg [31:0] desc_reg, baddr_reg, len_reg;
	reg tx_pend_reg, rx_pend_reg;
	reg [31:0] tx_ptr_reg, rx_ptr_reg;
	reg ovf_reg, txlow_reg, rxhigh_reg, frame_reg, parity_reg, txdone_reg;
	reg txerr_reg, rxerr_reg, txdmadone_reg, rxdmadone_reg;
	reg tx_ae_prev_reg, rx_af_prev_reg;

	// -----------------------------------------------------------
	// Combinational flags
	// -----------------------------------------------------------
	wire [AW+2:0] rx_total;
	wire [2:0] pipe_cnt;
	wire tx_empty, tx_full, rx_empty_fifo, rx_full, rx_empty, tx_ae, rx_af;
	wire tx_dma_idle, rx_dma_idle, tx_idle, local_irq, req_irq;
	wire pipe_out_v, rx_push, rx_store_ovf, tx_push, tx_pop, rx_pop;
	wire buf_ready, buf_pop, tx_need;
	wire wr_status, wr_tx_ptr, wr_rx_ptr, tx_abort;
	wire mem_err;

	assign pipe_cnt = {2'b00, pipe_v[0]} + {2'b00, pipe_v[1]}
		+ {2'b00, pipe_v[2]} + {2'b00, pipe_v[3]};
	assign rx_total = {2'b00, rx_count_reg} + {{AW{1'b0}}, pipe_cnt};
	// Full and transmit empty come from the DMA-side FIFOs; receive empty adds the pipeline
	assign tx_empty = (tx_count_reg == {(AW+1){1'b0}});
	assign tx_full = (tx_count_reg == DEPTH[AW:0]);
	assign rx_empty_fifo = (rx_count_reg == {(AW+1){1'b0}});
	assign rx_full = (rx_count_reg == DEPTH[AW:0]);
	assign rx_empty = rx_empty_fifo && (pipe_v == 4'h0);
	assign rx_af = (rx_total >= {2'b00, i_rx_high_watermark});
	assign tx_ae = (tx_count_reg < i_tx_low_watermark);

	// Idle when nothing queued or active
	assign tx_dma_idle = !tx_pend_reg
		&& !(ds_reg != DS_IDLE && dir_reg == `DIR_TX);
	assign rx_dma_idle = !rx_pend_reg
		&& !(ds_reg != DS_IDLE && dir_reg == `DIR_RX);
	assign tx_idle = (ts_reg == TS_IDLE);

	// Enabled channel sources before the master enable
	assign local_irq = (ovf_reg && i_rx_ovf_irq_en)
		|| (txlow_reg && i_tx_low_irq_en)
		|| (rxhigh_reg && i_rx_high_irq_en)
		|| (txdone_reg && i_tx_done_irq_en)
		|| i_force_irq;
	assign req_irq = (local_irq && i_chan_irq_en)
		|| (txdmadone_reg && i_tx_dma_irq_en)
		|| (rxdmadone_reg && i_rx_dma_irq_en);

	// Register port decode
	assign wr_status = i_reg_wr && (i_reg_addr == `OFS_STATUS);
	assign wr_tx_ptr = i_reg_wr && (i_reg_addr == `OFS_TX_PTR_COUNT);
	assign wr_rx_ptr = i_reg_wr && (i_reg_addr == `OFS_RX_PTR);
	assign tx_abort = wr_tx_ptr && (i_reg_wdata == `RESET_WORD);

	// Receive path: pipeline head into FIFO, overflow when full
	assign pipe_out_v = pipe_v[`RX_PIPE_DEPTH-1];
	assign rx_push = pipe_out_v && !rx_full && !i_rx_fifo_reset;
	assign rx_store_ovf = pipe_out_v && rx_full;

	// Transmit machine pulls words when the output buffer has room
	assign buf_ready = !buf1_v;
	assign buf_pop = o_tx_word_valid && i_tx_word_ready;
	assign tx_need = tick_reg && (ts_reg == TS_SEND) && i_tx_start
		&& buf_ready;
	assign tx_pop = tx_need && !tx_empty;

	// DMA side of the FIFOs
	assign mem_err = i_mem_target_abort || i_mem_master_abort;
	assign tx_push = o_mem_req && !o_mem_we && i_mem_ack
		&& (ds_reg == DS_XFER) && !mem_err;
	assign rx_pop = (ds_reg == DS_XFER) && (dir_reg == `DIR_RX)
		&& !o_mem_req && (len_reg != 32'h00000000) && !rx_empty_fifo
		&& !tx_abort;

	// -----------------------------------------------------------
	// Transmit FIFO
	// -----------------------------------------------------------
	// Word storage, written only by the DMA engine
	always @(posedge i_clk) begin
		if (tx_push) begin
			tx_mem[tx_wptr_reg] <= i_mem_rdata;
		end
	end

	// Pointers and count, cleared by the FIFO reset control
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_wptr_reg <= {AW{1'b0}};
			tx_rptr_reg <= {AW{1'b0}};
			tx_count_reg <= {(AW+1){1'b0}};
		end else if (i_tx_fifo_reset) begin
			tx_wptr_reg <= {AW{1'b0}};
			tx_rptr_reg <= {AW{1'b0}};
			tx_count_reg <= {(AW+1){1'b0}};
		end else begin
			if (tx_push) begin
				tx_wptr_reg <= tx_wptr_reg + 1'b1;
			end
			if (tx_pop) begin
				tx_rptr_reg <= tx_rptr_reg + 1'b1;
			end
			if (tx_push && !tx_pop) begin
				tx_count_reg <= tx_count_reg + 1'b1;
			end else if (tx_pop && !tx_push) begin
				tx_count_reg <= tx_count_reg - 1'b1;
			end
		end
	end

	// -----------------------------------------------------------
	// Receive pipeline and FIFO
	// -----------------------------------------------------------
	// Four-stage pipeline from the deserializer
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pipe_v <= 4'h0;
		end else if (i_rx_fifo_reset) begin
			pipe_v <= 4'h0;
		end else begin
			pipe_v <= {pipe_v[`RX_PIPE_DEPTH-2:0], i_rx_word_valid};
		end
	end

	// Pipeline data, qualified by valid bits
	always @(posedge i_clk) begin : rx_pipe_data
		integer k;
		pipe_d[0] <= i_rx_word;
		for (k = 1; k < `RX_PIPE_DEPTH; k = k + 1) begin
			pipe_d[k] <= pipe_d[k-1];
		end
		if (rx_push) begin
			rx_mem[rx_wptr_reg] <= pipe_d[`RX_PIPE_DEPTH-1];
		end
	end

	// Receive pointers and count
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_wptr_reg <= {AW{1'b0}};
			rx_rptr_reg <= {AW{1'b0}};
			rx_count_reg <= {(AW+1){1'b0}};
		end else if (i_rx_fifo_reset) begin
			rx_wptr_reg <= {AW{1'b0}};
			rx_rptr_reg <= {AW{1'b0}};
			rx_count_reg <= {(AW+1){1'b0}};
		end else begin
			if (rx_push) begin
				rx_wptr_reg <= rx_wptr_reg + 1'b1;
			end
			if (rx_pop) begin
				rx_rptr_reg <= rx_rptr_reg + 1'b1;
			end
			if (rx_push && !rx_pop) begin
				rx_count_reg <= rx_count_reg + 1'b1;
			end else if (rx_pop && !rx_push) begin
				rx_count_reg <= rx_count_reg - 1'b1;
			end
		end
	end

	// -----------------------------------------------------------
	// Transmit state machine and output buffer
	// -----------------------------------------------------------
	// Divider gives the one-in-sixteen machine rate
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_reg <= 4'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 4'h1;
			tick_reg <= (div_reg == `TX_SM_DIVIDE);
		end
	end

	// Finish task, pass stop state, then idle
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ts_reg <= TS_IDLE;
			o_tx_underflow <= 1'b0;
		end else if (i_tx_fifo_reset) begin
			ts_reg <= TS_IDLE;
			o_tx_underflow <= 1'b0;
		end else begin
			o_tx_underflow <= tx_need && tx_empty;
			if (tick_reg) begin
				case (ts_reg)
				TS_IDLE: begin
					if (i_tx_start && !tx_empty) begin
						ts_reg <= TS_SEND;
					end
				end
				TS_SEND: begin
					if (!i_tx_start || (buf_ready && tx_empty)) begin
						ts_reg <= TS_STOP;
					end
				end
				TS_STOP: begin
					ts_reg <= TS_IDLE;
				end
				default: begin
					ts_reg <= TS_IDLE;
				end
				endcase
			end
		end
	end

	// Two-entry buffer so a stalled receiver loses no word
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tx_word_valid <= 1'b0;
			o_tx_word <= `RESET_WORD;
			buf1_v <= 1'b0;
			buf1_d <= `RESET_WORD;
		end else if (i_tx_fifo_reset) begin
			o_tx_word_valid <= 1'b0;
			buf1_v <= 1'b0;
		end else if (buf_pop) begin
			o_tx_word_valid <= buf1_v || tx_pop;
			o_tx_word <= buf1_v ? buf1_d : tx_mem[tx_rptr_reg];
			buf1_v <= buf1_v && tx_pop;
			buf1_d <= tx_mem[tx_rptr_reg];
		end else if (tx_pop) begin
			if (!o_tx_word_valid) begin
				o_tx_word_valid <= 1'b1;
				o_tx_word <= tx_mem[tx_rptr_reg];
			end else begin
				buf1_v <= 1'b1;
				buf1_d <= tx_mem[tx_rptr_reg];
			end
		end
	end

	// -----------------------------------------------------------
	// Scatter-gather DMA engine, one direction at a time
	// -----------------------------------------------------------
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ds_reg <= DS_IDLE;
			dir_reg <= `DIR_TX;
			eoc_reg <= 1'b0;
			idx_reg <= 2'b00;
			desc_reg <= `RESET_WORD;
			baddr_reg <= `RESET_WORD;
			len_reg <= `RESET_WORD;
			tx_pend_reg <= 1'b0;
			rx_pend_reg <= 1'b0;
			tx_ptr_reg <= `RESET_WORD;
			rx_ptr_reg <= `RESET_WORD;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_addr <= `RESET_WORD;
			o_mem_wdata <= `RESET_WORD;
			txerr_reg <= 1'b0;
			rxerr_reg <= 1'b0;
			txdmadone_reg <= 1'b0;
			rxdmadone_reg <= 1'b0;
		end else begin
			// Sticky clears first, so a same-cycle set wins below
			if (wr_status) begin
				txerr_reg <= txerr_reg
					&& !i_reg_wdata[`ST_TX_DMA_ERR];
				rxerr_reg <= rxerr_reg && !i_reg_wdata[`ST_RX_DMA_ERR];
				txdmadone_reg <= txdmadone_reg
					&& !i_reg_wdata[`ST_TX_DMA_DONE];
				rxdmadone_reg <= rxdmadone_reg
					&& !i_reg_wdata[`ST_RX_DMA_DONE];
			end
			// Pointer writes queue a start; a zero transmit pointer write clears the queued start
			if (wr_tx_ptr) begin
				tx_pend_reg <= !tx_abort;
				tx_ptr_reg <= i_reg_wdata;
			end
			if (wr_rx_ptr) begin
				rx_pend_reg <= 1'b1;
				rx_ptr_reg <= i_reg_wdata;
			end
			case (ds_reg)
			DS_IDLE: begin
				o_mem_req <= 1'b0;
				if (tx_pend_reg && !tx_abort) begin
					tx_pend_reg <= wr_tx_ptr;
					dir_reg <= `DIR_TX;
					desc_reg <= {tx_ptr_reg[31:2], 2'b00};
					idx_reg <= 2'b00;
					ds_reg <= DS_FETCH;
				end else if (rx_pend_reg) begin
					rx_pend_reg <= wr_rx_ptr;
					dir_reg <= `DIR_RX;
					desc_reg <= {rx_ptr_reg[31:2], 2'b00};
					idx_reg <= 2'b00;
					ds_reg <= DS_FETCH;
				end
			end
			DS_FETCH: begin
				// Three longwords: buffer, length, next pointer
				if (!o_mem_req) begin
					o_mem_req <= 1'b1;
					o_mem_we <= 1'b0;
					o_mem_addr <= desc_reg + {28'h0000000, idx_reg, 2'b00};
				end else if (mem_err) begin
					o_mem_req <= 1'b0;
					ds_reg <= DS_IDLE;
				end else if (i_mem_ack) begin
					o_mem_req <= 1'b0;
					idx_reg <= idx_reg + 2'b01;
					if (idx_reg == 2'b00) begin
						baddr_reg <= i_mem_rdata;
					end else if (idx_reg == 2'b01) begin
						len_reg <= i_mem_rdata;
					end else begin
						eoc_reg <= i_mem_rdata[`PTR_EOC_BIT];
						desc_reg <= {i_mem_rdata[31:2], 2'b00};
						if (i_mem_rdata[`PTR_DIR_BIT] != dir_reg) begin
							ds_reg <= DS_IDLE;
							if (dir_reg == `DIR_TX) txerr_reg <= 1'b1;
							else rxerr_reg <= 1'b1;
						end else begin
							ds_reg <= DS_XFER;
						end
					end
				end
			end
			DS_XFER: begin
				if (!o_mem_req) begin
					if (len_reg == 32'h00000000) begin
						idx_reg <= 2'b00;
						ds_reg <= eoc_reg ? DS_IDLE : DS_FETCH;
						if (eoc_reg && !(tx_abort && dir_reg == `DIR_TX)) begin
							if (dir_reg == `DIR_TX) txdmadone_reg <= 1'b1;
							else rxdmadone_reg <= 1'b1;
						end
					end else if (dir_reg == `DIR_TX && !tx_full) begin
						o_mem_req <= 1'b1;
						o_mem_we <= 1'b0;
						o_mem_addr <= baddr_reg;
					end else if (rx_pop) begin
						o_mem_req <= 1'b1;
						o_mem_we <= 1'b1;
						o_mem_addr <= baddr_reg;
						o_mem_wdata <= rx_mem[rx_rptr_reg];
					end
				end else if (mem_err) begin
					o_mem_req <= 1'b0;
					ds_reg <= DS_IDLE;
				end else if (i_mem_ack) begin
					o_mem_req <= 1'b0;
					baddr_reg <= baddr_reg + 32'h00000004;
					len_reg <= len_reg - 32'h00000004;
				end
			end
			default: begin
				ds_reg <= DS_IDLE;
			end
			endcase
			// Abort of a running transmit list
			if (tx_abort && ds_reg != DS_IDLE && dir_reg == `DIR_TX) begin
				ds_reg <= DS_IDLE;
				o_mem_req <= 1'b0;
			end
			// Error sets: bus aborts; a wrong direction bit is flagged in the fetch step
			if (ds_reg != DS_IDLE && o_mem_req && mem_err) begin
				if (dir_reg == `DIR_TX) txerr_reg <= 1'b1;
				else rxerr_reg <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------
	// Channel sticky status
	// -----------------------------------------------------------
	// Write one clears, a same-cycle event keeps the bit set
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ovf_reg <= 1'b0;
			txlow_reg <= 1'b0;
			rxhigh_reg <= 1'b0;
			frame_reg <= 1'b0;
			parity_reg <= 1'b0;
			txdone_reg <= 1'b0;
			tx_ae_prev_reg <= 1'b1;
			rx_af_prev_reg <= 1'b0;
		end else begin
			tx_ae_prev_reg <= tx_ae;
			rx_af_prev_reg <= rx_af;
			ovf_reg <= rx_store_ovf || (ovf_reg
				&& !(wr_status && i_reg_wdata[`ST_RX_OVERFLOW]));
			txlow_reg <= (tx_ae && !tx_ae_prev_reg) || (txlow_reg
				&& !(wr_status && i_reg_wdata[`ST_TX_LOW]));
			rxhigh_reg <= (rx_af && !rx_af_prev_reg) || (rxhigh_reg
				&& !(wr_status && i_reg_wdata[`ST_RX_HIGH]));
			frame_reg <= i_rx_frame_err || (frame_reg
				&& !(wr_status && i_reg_wdata[`ST_RX_FRAME]));
			parity_reg <= i_rx_parity_err || (parity_reg
				&& !(wr_status && i_reg_wdata[`ST_RX_PARITY]));
			txdone_reg <= (tx_need && tx_empty) || (txdone_reg
				&& !(wr_status && i_reg_wdata[`ST_TX_DONE]));
		end
	end

	// -----------------------------------------------------------
	// Register reads and interrupt output
	// -----------------------------------------------------------
	// Read data a cycle after strobe; unmapped read as zero
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= `RESET_WORD;
			o_reg_rdata_valid <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_irq <= req_irq;
			o_reg_rdata_valid <= i_reg_rd;
			if (i_reg_rd && i_reg_addr == `OFS_STATUS) begin
				o_reg_rdata <= `RESET_WORD;
				o_reg_rdata[`ST_IRQ] <= req_irq;
				o_reg_rdata[`ST_LOCAL_IRQ] <= local_irq;
				o_reg_rdata[`ST_TX_IDLE] <= tx_idle;
				o_reg_rdata[`ST_TX_DMA_IDLE] <= tx_dma_idle;
				o_reg_rdata[`ST_RX_DMA_IDLE] <= rx_dma_idle;
				o_reg_rdata[`ST_RX_PARITY] <= parity_reg;
				o_reg_rdata[`ST_RX_OVERFLOW] <= ovf_reg;
				o_reg_rdata[`ST_RX_FRAME] <= frame_reg;
				o_reg_rdata[`ST_RX_DMA_DONE] <= rxdmadone_reg;
				o_reg_rdata[`ST_TX_DMA_DONE] <= txdmadone_reg;
				o_reg_rdata[`ST_RX_DMA_ERR] <= rxerr_reg;
				o_reg_rdata[`ST_TX_DMA_ERR] <= txerr_reg;
				o_reg_rdata[`ST_RX_HIGH] <= rxhigh_reg;
				o_reg_rdata[`ST_TX_LOW] <= txlow_reg;
				o_reg_rdata[`ST_TX_DONE] <= txdone_reg;
				o_reg_rdata[`ST_RX_FULL] <= rx_full;
				o_reg_rdata[`ST_RX_AFULL] <= rx_af;
				o_reg_rdata[`ST_RX_EMPTY] <= rx_empty;
				o_reg_rdata[`ST_TX_FULL] <= tx_full;
				o_reg_rdata[`ST_TX_AEMPTY] <= tx_ae;
				o_reg_rdata[`ST_TX_EMPTY] <= tx_empty;
			end else if (i_reg_rd && i_reg_addr == `OFS_TX_PTR_COUNT) begin
				o_reg_rdata <= {{(31-AW){1'b0}}, tx_count_reg};
			end else if (i_reg_rd) begin
				o_reg_rdata <= `RESET_WORD;
			end
		end
	end

endmodule // uart_channel_fifo_dma

`default_nettype wire

// >>> verif/uart_channel_fifo_dma_monitor.sv
`default_nettype none
module uart_channel_fifo_dma_monitor #(
	parameter AW = 11,
	parameter DW = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [4:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_reg_rdata_valid,
	input wire logic i_tx_fifo_reset,
	input wire logic i_rx_fifo_reset,
	input wire logic [AW:0] i_tx_low_watermark,
	input wire logic [AW:0] i_rx_high_watermark,
	input wire logic o_tx_word_valid,
	input wire logic [DW-1:0] o_tx_word,
	input wire logic i_tx_word_ready,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic i_mem_target_abort,
	input wire logic i_mem_master_abort,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// Port checks, all on the one clock
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	rd_answer_a:
	assert property (i_reg_rd |=> o_reg_rdata_valid)
		else $error("read not answered");
	rd_quiet_a:
	assert property (!i_reg_rd |=> !o_reg_rdata_valid)
		else $error("answer without read");
	irq_mirror_a:
	assert property (o_reg_rdata_valid && $past(i_reg_addr) == 5'h04
		|-> o_reg_rdata[31] == $past(o_irq)) else $error("irq bit differs");
	unmapped_zero_a:
	assert property (o_reg_rdata_valid && !($past(i_reg_addr) inside
		{5'h04, 5'h08}) |-> o_reg_rdata == 32'h0) else $error("bad read data");
	empty_code_a:
	assert property (o_reg_rdata_valid && $past(i_reg_addr) == 5'h04 &&
		$past(i_tx_fifo_reset, 2) && $past(i_rx_fifo_reset, 2) &&
		$past(i_tx_fifo_reset) && $past(i_rx_fifo_reset) &&
		$past(i_tx_low_watermark) != 0 && $past(i_rx_high_watermark) != 0
		|-> o_reg_rdata[6:0] == 7'h13) else $error("empty code wrong");
	req_hold_a:
	assert property (o_mem_req && !i_mem_ack && !i_mem_target_abort &&
		!i_mem_master_abort |=> o_mem_req && $stable(o_mem_addr) &&
		$stable(o_mem_we)) else $error("request not held");
	req_release_a:
	assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("request kept after ack");
	tx_hold_a:
	assert property (o_tx_word_valid && !i_tx_word_ready && !i_tx_fifo_reset
		|=> o_tx_word_valid && $stable(o_tx_word)) else $error("word dropped");
endmodule // uart_channel_fifo_dma_monitor

bind uart_channel_fifo_dma
	uart_channel_fifo_dma_monitor #(.AW(AW), .DW(DW)) mon (.*);
`default_nettype wire

// >>> verif/host_mem_model.sv
`default_nettype none
module host_mem_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [1:0] i_mode,
	input wire logic i_slow,
	output logic o_ack,
	output logic [31:0] o_rdata,
	output logic o_tabort,
	output logic o_mabort
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:255];
	logic [1:0] wait_cnt;
	// One request at a time; read data toggles when not answering
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{o_ack, o_tabort, o_mabort, wait_cnt} <= '0;
			o_rdata <= 32'h0;
		end else begin
			{o_ack, o_tabort, o_mabort} <= 3'h0;
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack && !o_tabort && !o_mabort) begin
				if (wait_cnt != 2'h0)
					wait_cnt <= wait_cnt - 2'h1;
				else if (i_mode != 2'h0)
					{o_mabort, o_tabort} <= i_mode;
				else begin
					o_ack <= 1'b1;
					wait_cnt <= {i_slow, i_slow};
					if (i_we)
						mem[i_addr[9:2]] <= i_wdata;
					else
						o_rdata <= mem[i_addr[9:2]];
				end
			end
		end
	end
endmodule // host_mem_model
`default_nettype wire

// >>> verif/uart_channel_fifo_dma_tb_top.sv
`default_nettype none
module uart_channel_fifo_dma_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam AW = 4;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
	mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
	logic i_clk, i_rst, i_reg_wr, i_reg_rd, i_tx_fifo_reset, i_rx_fifo_reset;
	logic i_chan_irq_en, i_force_irq, i_tx_dma_irq_en, i_rx_dma_irq_en;
	logic i_tx_low_irq_en, i_rx_high_irq_en, i_rx_ovf_irq_en, i_tx_done_irq_en;
	logic i_tx_start, i_rx_word_valid, i_rx_parity_err, i_rx_frame_err;
	logic i_tx_word_ready, slow, saw_unf;
	logic [4:0] i_reg_addr;
	logic [31:0] i_reg_wdata, i_rx_word, last, e, m, t;
	logic [AW:0] i_tx_low_watermark, i_rx_high_watermark;
	logic [1:0] mode;
	wire logic [31:0] o_reg_rdata, o_tx_word, o_mem_addr, o_mem_wdata;
	wire logic [31:0] i_mem_rdata;
	wire logic o_reg_rdata_valid, o_tx_word_valid, o_tx_underflow, o_mem_req;
	wire logic o_mem_we, i_mem_ack, i_mem_target_abort, i_mem_master_abort, o_irq;
	logic [31:0] rq[$], mq[$], tq[$], rxd[$];
	int mismatches, compares, cyc;
	uart_channel_fifo_dma #(.AW(AW)) dut (.*);
	host_mem_model host (.i_clk, .i_rst, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_mode(mode), .i_slow(slow),
		.o_ack(i_mem_ack), .o_rdata(i_mem_rdata), .o_tabort(i_mem_target_abort),
		.o_mabort(i_mem_master_abort));
	// ---------------------------------------------------------------
	// Clock, watchers and bus tasks
	// ---------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Compare read answers and sent words against the oldest notes
	always @(posedge i_clk) begin
		if (o_reg_rdata_valid === 1'b1 && rq.size() > 0) begin
			e = rq.pop_front();
			m = mq.pop_front();
			`CHK(o_reg_rdata & m, e)
		end
		if (o_tx_word_valid === 1'b1 && i_tx_word_ready === 1'b1
			&& tq.size() > 0) begin
			t = tq.pop_front();
			`CHK(o_tx_word, t)
		end
		if (o_tx_underflow === 1'b1)
			saw_unf = 1'b1;
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			give_verdict;
		end
		#1 i_tx_word_ready = $urandom_range(1);
	end
	task tick;
		@(posedge i_clk);
		#1;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] ex, input logic [31:0] mk);
		tick;
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		rq.push_back(ex & mk);
		mq.push_back(mk);
		tick;
		i_reg_rd = 1'b0;
		last = o_reg_rdata;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		tick;
		{i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
		tick;
		i_reg_wr = 1'b0;
	endtask
	task desc(input logic [7:0] i, input logic [31:0] b, l, n);
		host.mem[i] = b;
		host.mem[i + 8'h01] = l;
		host.mem[i + 8'h02] = n;
	endtask
	task wait_bit(input int b);
		repeat (4) tick;
		rd(5'h04, 32'h0, 32'h0);
		repeat (200)
			if (last[b] !== 1'b1)
				rd(5'h04, 32'h0, 32'h0);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{i_reg_wr, i_reg_rd, i_chan_irq_en, i_force_irq, i_tx_dma_irq_en,
			i_rx_dma_irq_en, i_tx_low_irq_en, i_rx_high_irq_en, i_rx_ovf_irq_en,
			i_tx_done_irq_en, i_tx_start, i_rx_word_valid, i_rx_parity_err,
			i_rx_frame_err, i_tx_word_ready, slow, saw_unf} = '0;
		{i_rst, i_tx_fifo_reset, i_rx_fifo_reset} = 3'h7;
		{i_reg_addr, i_reg_wdata, i_rx_word, mode} = '0;
		{i_tx_low_watermark, i_rx_high_watermark} = {5'h02, 5'h03};
		void'($urandom(32'hEFCF5503));
		repeat (10) @(posedge i_clk);
		#1 i_rst = 1'b0;
		rd(5'h04, 32'h20C00013, 32'hE0C0007F);
		$display("test empty done");
		{i_tx_fifo_reset, i_rx_fifo_reset} = 2'h0;
		for (int k = 0; k < 18; k++) begin
			tick;
			{i_rx_word_valid, i_rx_word} = {1'b1, $urandom};
			if (k < 16)
				rxd.push_back(i_rx_word);
		end
		tick;
		{i_rx_word_valid, i_rx_parity_err, i_rx_frame_err} = 3'h3;
		tick;
		{i_rx_parity_err, i_rx_frame_err} = 2'h0;
		repeat (6) tick;
		rd(5'h04, 32'h000D0860, 32'h000D0870);
		wr(5'h04, 32'h00040000);
		rd(5'h04, 32'h00090860, 32'h000D0870);
		wr(5'h04, 32'h00090800);
		rd(5'h04, 32'h00000060, 32'h000D0870);
		$display("test receive done");
		slow = 1'b1;
		desc(8'h40, 32'h200, 32'h8, 32'h3);
		wr(5'h0C, 32'h00000100);
		wait_bit(22);
		rd(5'h04, 32'h00408000, 32'h00408000);
		`CHK(host.mem[8'h80], rxd[0])
		`CHK(host.mem[8'h81], rxd[1])
		desc(8'h50, 32'h300, 32'hC, 32'h1);
		for (int k = 0; k < 3; k++) begin
			host.mem[8'hC0 + k] = $urandom;
			tq.push_back(host.mem[8'hC0 + k]);
		end
		i_tx_start = 1'b1;
		wr(5'h08, 32'h00000140);
		wait_bit(8);
		rd(5'h04, 32'h00804502, 32'h00804502);
		rd(5'h08, 32'h0, 32'hFFFFFFFF);
		`CHK(saw_unf, 1'b1)
		`CHK(tq.size(), 0)
		$display("test transmit done");
		slow = 1'b0;
		desc(8'h60, 32'h200, 32'h4, 32'h1);
		wr(5'h0C, 32'h00000180);
		wait_bit(22);
		mode = 2'h2;
		wr(5'h08, 32'h00000140);
		wait_bit(23);
		mode = 2'h0;
		rd(5'h04, 32'h00003000, 32'h00003000);
		wr(5'h04, 32'h00003000);
		tick;
		{i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, 5'h08, 32'h00000140};
		tick;
		i_reg_wdata = 32'h0;
		tick;
		i_reg_wr = 1'b0;
		repeat (4) tick;
		rd(5'h04, 32'h00800000, 32'h00801000);
		$display("test errors done");
		{i_chan_irq_en, i_force_irq, i_tx_dma_irq_en, i_rx_dma_irq_en} = 4'hF;
		{i_tx_low_irq_en, i_rx_high_irq_en, i_rx_ovf_irq_en, i_tx_done_irq_en} = 4'hF;
		rd(5'h04, 32'hC0000000, 32'hC0000000);
		{i_chan_irq_en, i_force_irq, i_tx_dma_irq_en, i_rx_dma_irq_en} = 4'h0;
		rd(5'h04, 32'h40000000, 32'hC0000000);
		`CHK(o_irq, 1'b0)
		$display("test interrupt done");
		give_verdict;
	end
endmodule // uart_channel_fifo_dma_tb_top
`default_nettype wire
